// *** pgs_pkg.sv ***
/*
 * Shared constants of the power-good and strap sampler: register map,
 * field positions, reset values and cycle counts.
 * Assumes a byte-addressed classic Wishbone slave with 32-bit data.
 */
package pgs_pkg;

  // Register byte offsets
  localparam logic [7:0] PGS_STATUS_OFS = 8'h00;
  localparam logic [7:0] PGS_HP_ENABLE_OFS = 8'h48;
  localparam logic [7:0] PGS_HP_CONTROL_OFS = 8'h4C;
  localparam logic [7:0] PGS_HP_SHIFT_OFS = 8'h50;
  localparam logic [7:0] PGS_COMP0_OFS = 8'hE0;
  localparam logic [7:0] PGS_COMP_STEP = 8'h04;
  localparam int PGS_COMP_REGS = 3;

  // Status register fields
  localparam int PGS_ST_PG_OK_BIT = 0;
  localparam int PGS_ST_TEST_BIT = 1;
  localparam int PGS_ST_OVR_BIT = 2;
  localparam int PGS_ST_WARM_BIT = 3;
  localparam int PGS_ST_BUSY_BIT = 4;

  // Hot plug enable register fields
  localparam int PGS_HPEN_A_BIT = 0;
  localparam int PGS_HPEN_B_BIT = 1;

  // Compensation register fields
  localparam int PGS_COMP_A_BIT = 0;
  localparam int PGS_COMP_B_BIT = 1;
  localparam int PGS_COMP_VAL_LSB = 8;
  localparam int PGS_COMP_VAL_W = 8;
  localparam int PGS_COMP_W = 16;

  // Widths and reset values
  localparam int PGS_HP_CTRL_W = 8;
  localparam int PGS_SHIFT_W = 8;
  localparam logic [7:0] PGS_HP_CTRL_RST = 8'h00;
  localparam logic [15:0] PGS_COMP_RST = 16'h0000;

  // Power good must stay high for more than 6 reference clock cycles
  localparam int PGS_PG_GLITCH_CYCLES = 6;
  localparam logic [3:0] PGS_PG_FILTER_COUNT = 4'(PGS_PG_GLITCH_CYCLES + 1);

  // System clock cycles per half period of the hot plug serial clock
  localparam logic [3:0] PGS_SHIFT_HALF = 4'h4;

  typedef enum logic [2:0] {
    PGS_SH_IDLE = 3'b001,
    PGS_SH_SHIFT = 3'b010,
    PGS_SH_LOAD = 3'b100
  } pgs_shift_state_t;

endpackage

// *** pgs_hp_if.sv ***
/*
 * Carrier between the sampler core and the hot plug shifter.
 * Assumes both ends run on the system clock.
 */
`timescale 1ns/1ns
interface pgs_hp_if;
  logic enable_a;
  logic enable_b;
  logic hp_reset_n;
  logic load;
  logic [7:0] data;
  logic busy;
  logic serial_data;
  logic serial_clk;
  logic load_n;

  modport core (
    output enable_a, enable_b, hp_reset_n, load, data,
    input busy, serial_data, serial_clk, load_n
  );
  modport shifter (
    input enable_a, enable_b, hp_reset_n, load, data,
    output busy, serial_data, serial_clk, load_n
  );
endinterface

// *** pgs_pg_deglitch.sv ***
/*
 * Deglitch of the power-good input against the reference clock.
 * Assumes power good and the reference clock are synchronous to clk_sys_i.
 */
`timescale 1ns/1ns
module pgs_pg_deglitch
  import pgs_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  // Pins
  input wire logic power_good_i,
  input wire logic reference_clock_i,
  // Filtered level
  output logic power_good_ok_o
);

  logic ref_q;
  logic [3:0] count;
  logic ref_rise;

  assign ref_rise = reference_clock_i & ~ref_q;

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ref_q <= 1'b0;
    end else begin
      ref_q <= reference_clock_i;
    end
  end

  // Counts reference edges seen high; a low level restarts the count
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      count <= 4'h0;
      power_good_ok_o <= 1'b0;
    end else if (!power_good_i) begin
      count <= 4'h0;
      power_good_ok_o <= 1'b0;
    end else if (ref_rise && !power_good_ok_o) begin
      count <= 4'(count + 4'h1);
      if (4'(count + 4'h1) >= PGS_PG_FILTER_COUNT) begin
        power_good_ok_o <= 1'b1; // RQ7
      end
    end
  end

endmodule

// *** pgs_hp_shift.sv ***
/*
 * Hot plug serial output shifter: shifts a byte out msb first, then
 * pulses the load strobe low for one serial half period.
 * Assumes load is a one-cycle pulse from the register interface.
 */
`timescale 1ns/1ns
module pgs_hp_shift
  import pgs_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  // Core side
  pgs_hp_if.shifter hp
);

  pgs_shift_state_t state;
  logic [7:0] shreg;
  logic [3:0] bits_left;
  logic [3:0] div;
  logic tick;
  logic active;

  assign active = hp.enable_a | hp.enable_b;
  assign tick = (div == PGS_SHIFT_HALF - 4'h1);
  assign hp.busy = (state != PGS_SH_IDLE);
  assign hp.serial_data = shreg[PGS_SHIFT_W-1];

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      div <= 4'h0;
    end else if (tick || state == PGS_SH_IDLE) begin
      div <= 4'h0;
    end else begin
      div <= 4'(div + 4'h1);
    end
  end

  // Reset pin clears shift register and sequencer
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state <= PGS_SH_IDLE;
      shreg <= 8'h00;
      bits_left <= 4'h0;
      hp.serial_clk <= 1'b1;
      hp.load_n <= 1'b1;
    end else if (!hp.hp_reset_n) begin
      state <= PGS_SH_IDLE; // RQ9
      shreg <= 8'h00; // RQ9
      bits_left <= 4'h0;
      hp.serial_clk <= 1'b1;
      hp.load_n <= 1'b1;
    end else begin
      case (state)
        PGS_SH_IDLE: begin
          hp.serial_clk <= 1'b1;
          hp.load_n <= 1'b1;
          if (hp.load && active) begin
            shreg <= hp.data;
            bits_left <= 4'(PGS_SHIFT_W);
            state <= PGS_SH_SHIFT;
          end
        end
        PGS_SH_SHIFT: begin
          if (tick) begin
            hp.serial_clk <= ~hp.serial_clk;
            if (!hp.serial_clk) begin
              shreg <= {shreg[PGS_SHIFT_W-2:0], 1'b0};
              bits_left <= 4'(bits_left - 4'h1);
              if (bits_left == 4'h1) begin
                state <= PGS_SH_LOAD;
                hp.load_n <= 1'b0;
              end
            end
          end
        end
        PGS_SH_LOAD: begin
          hp.serial_clk <= 1'b1;
          if (tick) begin
            hp.load_n <= 1'b1;
            state <= PGS_SH_IDLE;
          end
        end
        default: begin
          state <= PGS_SH_IDLE;
        end
      endcase
    end
  end

endmodule

// *** pgs_power_good_strap_sampler.sv ***
/*
 * Reset-entry logic: power-good deglitch, strap sampling while power
 * good is low, hot plug pin direction, compensation defaults and the
 * register file on classic Wishbone.
 * Assumes all pins are synchronous to clk_sys_i and that the reference
 * clock toggles slower than half the system clock.
 */
`timescale 1ns/1ns
// Overview of operation
// (RQ1) Serial data-out pin is input while power good low, output otherwise.
// (RQ2) Level on data-out pin while power good low is bridge A hot plug enable.
// (RQ3) With neither bridge in hot plug mode, data-out pin is driven low.
// (RQ4) Interrupt line C low at power-good rise enters production test mode.
// (RQ5) Override low runs automatic compensation; high uses register values.
// (RQ6) Side A and B compensation fields default to the captured override.
// (RQ7) Power-good rise is seen only after more than 6 reference cycles high.
// (RQ8) System runs reference clock 200 us before and during power good.
// (RQ9) Reset input clears hot plug shift register and control latches.
// (RQ10) Level on input-load pin while power good low is bridge B enable.
// (RQ11) System holds reset at least 1 ms after power good, and on warm reset.
// (RQ12) Straps captured at filtered power-good rise, held until it falls.
module pgs_power_good_strap_sampler
  import pgs_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  // Board pins
  input wire logic power_good_i,
  input wire logic reference_clock_i,
  input wire logic reset_n_i,
  input wire logic legacy_irq_c_n_i,
  input wire logic compensation_override_i,
  // Hot plug serial data-out pin
  input wire logic hotplug_serial_out_data_i,
  output logic hotplug_serial_out_data_o,
  output logic hotplug_serial_out_data_oe_n_o,
  // Hot plug serial input-load pin
  input wire logic hotplug_serial_in_load_n_i,
  output logic hotplug_serial_in_load_n_o,
  output logic hotplug_serial_in_load_n_oe_n_o,
  // Hot plug serial clock
  output logic hotplug_serial_clk_o,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Core status and control
  output logic power_good_ok_o,
  output logic test_mode_o,
  output logic comp_auto_enable_o,
  output logic [PGS_COMP_REGS*PGS_COMP_W-1:0] comp_ctrl_o,
  output logic [PGS_HP_CTRL_W-1:0] hotplug_control_o,
  output logic bridge_a_hotplug_enable_o,
  output logic bridge_b_hotplug_enable_o
);

  pgs_hp_if hp ();

  logic pg_ok;
  logic pg_ok_q;
  logic pg_rise;
  logic pin_drive;
  logic hp_active;
  logic override_strap;
  logic [PGS_HP_CTRL_W-1:0] hp_control;
  logic [PGS_COMP_W-1:0] comp [PGS_COMP_REGS];
  logic wb_req;
  logic wb_wr;
  logic [31:0] next_rdata;
  logic shift_load;
  logic sel_ctrl;
  logic sel_shift;
  logic [31:0] status_word;

  pgs_pg_deglitch u_deglitch (
    .clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i),
    .power_good_i(power_good_i),
    .reference_clock_i(reference_clock_i),
    .power_good_ok_o(pg_ok)
  );

  pgs_hp_shift u_shift (
    .clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i),
    .hp(hp.shifter)
  );

  assign pg_rise = pg_ok & ~pg_ok_q;
  assign hp_active = bridge_a_hotplug_enable_o | bridge_b_hotplug_enable_o;
  // Release the pins at once when the raw input drops
  assign pin_drive = pg_ok & power_good_i;
  assign power_good_ok_o = pg_ok;

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pg_ok_q <= 1'b0;
    end else begin
      pg_ok_q <= pg_ok;
    end
  end

  // Straps follow the pins while filtered power good is low and freeze on
  // its rise; the reset pin does not touch them
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bridge_a_hotplug_enable_o <= 1'b0;
    end else if (!pg_ok) begin
      bridge_a_hotplug_enable_o <= hotplug_serial_out_data_i; // RQ2 RQ12
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bridge_b_hotplug_enable_o <= 1'b0;
    end else if (!pg_ok) begin
      bridge_b_hotplug_enable_o <= hotplug_serial_in_load_n_i; // RQ10 RQ12
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      test_mode_o <= 1'b0;
    end else if (!pg_ok) begin
      test_mode_o <= ~legacy_irq_c_n_i; // RQ4 RQ12
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      override_strap <= 1'b0;
    end else if (!pg_ok) begin
      override_strap <= compensation_override_i; // RQ12
    end
  end

  // Pin direction follows power good
  assign hotplug_serial_out_data_oe_n_o = ~pin_drive; // RQ1
  assign hotplug_serial_in_load_n_oe_n_o = ~pin_drive;

  // Pin values: idle levels when no bridge runs hot plug; one register
  // per pin so each keeps its own idle level
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      hotplug_serial_out_data_o <= 1'b0;
    end else if (!hp_active) begin
      hotplug_serial_out_data_o <= 1'b0; // RQ3
    end else begin
      hotplug_serial_out_data_o <= hp.serial_data;
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      hotplug_serial_in_load_n_o <= 1'b1;
    end else if (!hp_active) begin
      hotplug_serial_in_load_n_o <= 1'b1;
    end else begin
      hotplug_serial_in_load_n_o <= hp.load_n;
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      hotplug_serial_clk_o <= 1'b1;
    end else if (!hp_active) begin
      hotplug_serial_clk_o <= 1'b1;
    end else begin
      hotplug_serial_clk_o <= hp.serial_clk;
    end
  end

  // Automatic compensation follows the live override input
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      comp_auto_enable_o <= 1'b1;
    end else begin
      comp_auto_enable_o <= ~compensation_override_i; // RQ5
    end
  end

  // Wishbone handshake: ack one cycle after the request, then drop
  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wb_wr = wb_req & wb_we_i;
  assign shift_load = sel_shift & wb_sel_i[0];

  // Write decode of the two hot plug registers
  assign sel_ctrl = wb_wr && wb_adr_i == PGS_HP_CONTROL_OFS;
  assign sel_shift = wb_wr && wb_adr_i == PGS_HP_SHIFT_OFS;

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_req;
    end
  end

  // Hot plug control latches
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      hp_control <= PGS_HP_CTRL_RST;
    end else if (!reset_n_i) begin
      hp_control <= PGS_HP_CTRL_RST; // RQ9
    end else if (sel_ctrl && wb_sel_i[0]) begin
      hp_control <= wb_dat_i[PGS_HP_CTRL_W-1:0];
    end
  end

  assign hotplug_control_o = hp_control;

  // Compensation registers; fields reload from the strap on power-good rise
  genvar gi;
  generate
    for (gi = 0; gi < PGS_COMP_REGS; gi++) begin : g_comp
      localparam logic [7:0] OFS = 8'(PGS_COMP0_OFS + gi * PGS_COMP_STEP);
      logic hit;
      assign hit = wb_wr && wb_adr_i == OFS;
      // Reload on power-good rise wins over a write in the same cycle
      always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
          comp[gi] <= PGS_COMP_RST;
        end else if (pg_rise) begin
          comp[gi][PGS_COMP_A_BIT] <= override_strap; // RQ6
          comp[gi][PGS_COMP_B_BIT] <= override_strap; // RQ6
        end else if (hit) begin
          if (wb_sel_i[0]) begin
            comp[gi][PGS_COMP_B_BIT:PGS_COMP_A_BIT] <=
              wb_dat_i[PGS_COMP_B_BIT:PGS_COMP_A_BIT];
          end
          if (wb_sel_i[1]) begin
            comp[gi][PGS_COMP_VAL_LSB +: PGS_COMP_VAL_W] <=
              wb_dat_i[PGS_COMP_VAL_LSB +: PGS_COMP_VAL_W];
          end
        end
      end
      assign comp_ctrl_o[gi*PGS_COMP_W +: PGS_COMP_W] = comp[gi]; // RQ5
    end
  endgenerate

  // Shifter connection
  assign hp.enable_a = bridge_a_hotplug_enable_o;
  assign hp.enable_b = bridge_b_hotplug_enable_o;
  assign hp.hp_reset_n = reset_n_i; // RQ9
  assign hp.load = shift_load;
  assign hp.data = wb_dat_i[PGS_SHIFT_W-1:0];

  // Status register image
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[PGS_ST_PG_OK_BIT] = pg_ok;
    status_word[PGS_ST_TEST_BIT] = test_mode_o;
    status_word[PGS_ST_OVR_BIT] = compensation_override_i;
    status_word[PGS_ST_WARM_BIT] = ~reset_n_i;
    status_word[PGS_ST_BUSY_BIT] = hp.busy;
  end

  // Read mux; unmapped offsets read zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (wb_adr_i)
      PGS_STATUS_OFS: begin
        next_rdata = status_word;
      end
      PGS_HP_ENABLE_OFS: begin
        next_rdata[PGS_HPEN_A_BIT] = bridge_a_hotplug_enable_o;
        next_rdata[PGS_HPEN_B_BIT] = bridge_b_hotplug_enable_o;
      end
      PGS_HP_CONTROL_OFS: begin
        next_rdata[PGS_HP_CTRL_W-1:0] = hp_control;
      end
      PGS_HP_SHIFT_OFS: begin
        next_rdata[PGS_ST_BUSY_BIT] = hp.busy;
      end
      PGS_COMP0_OFS: begin
        next_rdata[PGS_COMP_W-1:0] = comp[0];
      end
      8'(PGS_COMP0_OFS + PGS_COMP_STEP): begin
        next_rdata[PGS_COMP_W-1:0] = comp[1];
      end
      8'(PGS_COMP0_OFS + 2 * PGS_COMP_STEP): begin
        next_rdata[PGS_COMP_W-1:0] = comp[2];
      end
      default: begin
        next_rdata = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (wb_req && !wb_we_i) begin
      wb_dat_o <= next_rdata;
    end
  end

endmodule

// *** pgs_assertions.sv ***
/* Checker of pin direction, strap capture and power good filtering.
   Assumes it is bound to the top module of the sampler. */
`timescale 1ns/1ns
module pgs_assertions (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  // Pins
  input wire logic power_good_i,
  input wire logic reference_clock_i,
  input wire logic reset_n_i,
  input wire logic legacy_irq_c_n_i,
  input wire logic compensation_override_i,
  input wire logic hotplug_serial_out_data_i,
  input wire logic hotplug_serial_out_data_o,
  input wire logic hotplug_serial_out_data_oe_n_o,
  input wire logic hotplug_serial_in_load_n_i,
  input wire logic hotplug_serial_in_load_n_o,
  // Core outputs
  input wire logic power_good_ok_o,
  input wire logic test_mode_o,
  input wire logic comp_auto_enable_o,
  input wire logic [47:0] comp_ctrl_o,
  input wire logic [7:0] hotplug_control_o,
  input wire logic bridge_a_hotplug_enable_o,
  input wire logic bridge_b_hotplug_enable_o
);
  logic ref_q;
  logic [3:0] ref_cnt;
  logic [5:0] fields;
  assign fields = {comp_ctrl_o[33:32], comp_ctrl_o[17:16], comp_ctrl_o[1:0]};
  // Reference rising edges seen while power good stays high
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ref_q <= 1'b0;
      ref_cnt <= 4'h0;
    end else begin
      ref_q <= reference_clock_i;
      if (!power_good_i) ref_cnt <= 4'h0;
      else if (reference_clock_i && !ref_q && ref_cnt != 4'hF)
        ref_cnt <= ref_cnt + 4'h1;
    end
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  sequence s_pg_rise;
    $rose(power_good_ok_o);
  endsequence
  sequence s_warm;
    !reset_n_i;
  endsequence
  AST_PG_FILTER: assert property (s_pg_rise |-> ref_cnt >= 4'h7)
    else $error("power good seen too early");
  AST_PIN_INPUT: assert property (
    !power_good_ok_o |-> hotplug_serial_out_data_oe_n_o)
    else $error("data pin driven while power good low");
  AST_PIN_OUTPUT: assert property (
    power_good_ok_o && power_good_i |-> !hotplug_serial_out_data_oe_n_o)
    else $error("data pin not driven");
  AST_STRAP_HP: assert property (s_pg_rise |->
    bridge_a_hotplug_enable_o == $past(hotplug_serial_out_data_i) &&
    bridge_b_hotplug_enable_o == $past(hotplug_serial_in_load_n_i))
    else $error("hot plug strap wrong");
  AST_TEST_ENTRY: assert property (
    s_pg_rise |-> test_mode_o == !$past(legacy_irq_c_n_i))
    else $error("test mode strap wrong");
  AST_STRAP_HOLD: assert property (
    power_good_ok_o && $past(power_good_ok_o) |-> $stable({test_mode_o,
    bridge_a_hotplug_enable_o, bridge_b_hotplug_enable_o}))
    else $error("strap changed while power good");
  AST_COMP_DEFAULT: assert property (
    s_pg_rise |-> ##1 fields == {6{$past(compensation_override_i, 2)}})
    else $error("compensation default wrong");
  AST_COMP_MODE: assert property (
    $past(resetn_i) |-> comp_auto_enable_o == !$past(compensation_override_i))
    else $error("compensation mode wrong");
  AST_NO_HP_LOW: assert property (power_good_ok_o &&
    $past(power_good_ok_o, 2) && !bridge_a_hotplug_enable_o &&
    !bridge_b_hotplug_enable_o |-> !hotplug_serial_out_data_o &&
    hotplug_serial_in_load_n_o)
    else $error("idle hot plug pins wrong");
  AST_WARM_CLEAR: assert property (
    s_warm ##1 s_warm |-> ##1 hotplug_control_o == 8'h00)
    else $error("control latch not cleared");
endmodule

// *** pgs_board_model.sv ***
/* Board side: reference clock source, weak strap resistors on the
   two hot plug pins and a serial receiver on the hot plug output.
   Assumes clk_sys_i at 250 MHz. */
`timescale 1ns/1ns
module pgs_board_model (
  // Clock
  input wire logic clk_sys_i,
  // Strap resistors
  input wire logic pull_a_i,
  input wire logic pull_b_i,
  // Device pin drivers
  input wire logic od_i,
  input wire logic od_oe_n_i,
  input wire logic il_i,
  input wire logic il_oe_n_i,
  input wire logic sclk_i,
  // Resolved levels
  output logic ref_o,
  output logic od_o,
  output logic il_o,
  // Word taken by the receiver when the load strobe returns high
  output logic [7:0] latch_o
);
  logic [1:0] phase = 2'b00;
  logic sclk_q = 1'b1;
  logic ld_q = 1'b1;
  logic [7:0] sh = 8'h00;
  // Runs from time zero and never stops, near 62.5 MHz
  always @(posedge clk_sys_i) begin
    phase <= phase + 2'b01;
  end
  assign ref_o = phase[1];
  // Bit taken as the serial clock falls, word as the load strobe rises
  always @(posedge clk_sys_i) begin
    sclk_q <= sclk_i;
    ld_q <= il_o;
    if (sclk_q && !sclk_i) sh <= {sh[6:0], od_o};
    if (!ld_q && il_o) latch_o <= sh;
  end
  // Undriven pin settles to its resistor
  assign od_o = od_oe_n_i ? pull_a_i : od_i;
  assign il_o = il_oe_n_i ? pull_b_i : il_i;
endmodule

// *** tb_power_good_strap_sampler.sv ***
/* Self-checking bench of the power good strap sampler.
   Assumes the board model and checker are compiled before it. */
`timescale 1ns/1ns
module tb_power_good_strap_sampler;
  import pgs_pkg::*;
  logic clk_sys_i, resetn_i, power_good_i, reference_clock_i, reset_n_i;
  logic legacy_irq_c_n_i, compensation_override_i, wb_cyc_i, wb_stb_i;
  logic hotplug_serial_out_data_i, hotplug_serial_out_data_o;
  logic hotplug_serial_out_data_oe_n_o, hotplug_serial_in_load_n_i;
  logic hotplug_serial_in_load_n_o, hotplug_serial_in_load_n_oe_n_o;
  logic hotplug_serial_clk_o, wb_we_i, wb_ack_o, power_good_ok_o;
  logic test_mode_o, comp_auto_enable_o;
  logic bridge_a_hotplug_enable_o, bridge_b_hotplug_enable_o, pull_a, pull_b;
  logic [7:0] wb_adr_i, hotplug_control_o;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic [47:0] comp_ctrl_o;
  logic [7:0] shift_latch;
  int fails, compares, seed;
  pgs_power_good_strap_sampler pgs_power_good_strap_sampler_i (.*);
  pgs_board_model pgs_board_model_i (
    .clk_sys_i(clk_sys_i),
    .pull_a_i(pull_a),
    .pull_b_i(pull_b),
    .od_i(hotplug_serial_out_data_o),
    .od_oe_n_i(hotplug_serial_out_data_oe_n_o),
    .il_i(hotplug_serial_in_load_n_o),
    .il_oe_n_i(hotplug_serial_in_load_n_oe_n_o),
    .sclk_i(hotplug_serial_clk_o),
    .ref_o(reference_clock_i),
    .od_o(hotplug_serial_out_data_i),
    .il_o(hotplug_serial_in_load_n_i),
    .latch_o(shift_latch)
  );
  function automatic logic [31:0] hpen_exp(input logic a, input logic b);
    return {30'h0, b, a};
  endfunction
  function automatic logic [31:0] comp_exp(input logic o);
    return {30'h0, o, o};
  endfunction
  function automatic logic [31:0] st_exp(input logic t, o, w);
    return {28'h0, w, o, t, 1'b1};
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic final_report;
    if (fails == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_sys_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_sel_i <= 4'hF;
    wb_adr_i <= a;
    wb_dat_i <= d;
    k = 0;
    do begin
      @(posedge clk_sys_i);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 20);
    if (k >= 20) fails++;
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic pcyc(input int i);
    logic a, b, t, o;
    logic [31:0] d;
    int k;
    a = (i == 0) ? 1'b0 : (i == 2) ? 1'b1 : 1'($random(seed));
    b = (i == 0) ? 1'b0 : 1'($random(seed));
    t = (i == 1);
    o = 1'($random(seed));
    d = $random(seed) | 32'h1;
    @(posedge clk_sys_i);
    pull_a <= a;
    pull_b <= b;
    legacy_irq_c_n_i <= !t;
    compensation_override_i <= o;
    reset_n_i <= 1'b0;
    power_good_i <= 1'b1;
    repeat (16) @(posedge clk_sys_i);
    power_good_i <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    chk(power_good_ok_o, 32'h0);
    chk(hotplug_serial_out_data_oe_n_o, 32'h1);
    power_good_i <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_sys_i);
      k++;
    end while (power_good_ok_o !== 1'b1 && k < 100);
    chk(k > 24 && k < 40, 32'h1);
    legacy_irq_c_n_i <= t;
    pull_a <= !a;
    pull_b <= !b;
    wb(1'b0, PGS_HP_ENABLE_OFS, 32'h0);
    chk(rd, hpen_exp(a, b));
    wb(1'b0, PGS_STATUS_OFS, 32'h0);
    chk(rd, st_exp(t, o, 1'b1));
    for (int r = 0; r < 3; r++) begin
      wb(1'b0, PGS_COMP0_OFS + 8'(r) * PGS_COMP_STEP, 32'h0);
      chk(rd, comp_exp(o));
    end
    reset_n_i <= 1'b1;
    wb(1'b1, PGS_HP_CONTROL_OFS, d);
    chk(hotplug_control_o, d[7:0]);
    if (a | b) begin
      wb(1'b1, PGS_HP_SHIFT_OFS, d);
      repeat (80) @(posedge clk_sys_i);
      chk(shift_latch, d[7:0]);
      wb(1'b1, PGS_HP_SHIFT_OFS, ~d);
      wb(1'b0, PGS_HP_SHIFT_OFS, 32'h0);
      chk(rd & 32'h10, 32'h10);
    end else begin
      chk(hotplug_serial_out_data_i, 32'h0);
    end
    wb(1'b1, 8'h10, d);
    wb(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h0);
    reset_n_i <= 1'b0;
    compensation_override_i <= !o;
    repeat (4) @(posedge clk_sys_i);
    chk(hotplug_control_o, 32'h0);
    chk(comp_auto_enable_o, o);
    chk(test_mode_o, t);
    chk({bridge_b_hotplug_enable_o, bridge_a_hotplug_enable_o},
        hpen_exp(a, b));
    reset_n_i <= 1'b1;
    wb(1'b0, PGS_HP_SHIFT_OFS, 32'h0);
    chk(rd & 32'h10, 32'h0);
    wb(1'b0, PGS_COMP0_OFS, 32'h0);
    chk(rd, comp_exp(o));
    power_good_i <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    chk(hotplug_serial_out_data_oe_n_o, 32'h1);
  endtask
  initial begin
    clk_sys_i = 1'b0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end
  initial begin
    #80000;
    fails++;
    final_report;
  end
  initial begin
    seed = 32'h119C;
    resetn_i = 1'b0;
    power_good_i = 1'b0;
    reset_n_i = 1'b0;
    legacy_irq_c_n_i = 1'b1;
    compensation_override_i = 1'b0;
    pull_a = 1'b0;
    pull_b = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hF;
    wb_dat_i = 32'h0;
    repeat (4) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      pcyc(i);
    end
    final_report;
  end
endmodule
bind pgs_power_good_strap_sampler pgs_assertions pgs_assertions_i (.*);
